// ==== hw/tmr_top.sv ====
// module: sixteen-bit timer with seven modes and comparator counting
`default_nettype none
module tmr_top
	import tmr_pkg::*;
#(
	parameter int CNT_W = 16 // counter width
)
(
	input wire logic clk, // system clock, 40 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction, 1 = write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic cmp_out, // analog comparator output, synchronous
	input wire logic tmr_in, // timer input pin, synchronous
	output logic tmr_out, // timer output level
	output logic tmr_out_en, // timer output alternate function enabled
	output logic irq // level interrupt
);
	tmr_reg_if bus ();

	logic [CTRL_W-1:0] ctrl_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] rld_q;
	logic [CNT_W-1:0] pwm_q;
	logic [CNT_W-1:0] cap_q;
	logic [ST_W-1:0] stat_q;
	logic [ST_W-1:0] mask_q;
	logic [ST_W-1:0] stat_set;
	logic [7:0] pre_q;
	logic out_q;
	logic irq_q;
	logic out_en_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_mux;
	logic en;
	logic pol;
	logic out_en_bit;
	logic [2:0] pre_sel;
	tmr_mode_t mode;
	logic pre_tick;
	logic cmp_edge;
	logic tin_edge;
	logic tin_other;
	logic count_step;
	logic at_reload;
	logic reload_ev;
	logic match_ev;
	logic capture_ev;
	logic gate_ev;
	logic gate_active;
	logic wr_ctrl;

	tmr_apb u_apb
	(
		.clk(clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pready(pready),
		.pslverr(pslverr),
		.bus(bus)
	);

	// comparator edges; a signal faster than half the clock may merge edges
	tmr_edge u_cmp_edge
	(
		.clk(clk),
		.rst(rst),
		.sig(cmp_out),
		.fall_sel(pol),
		.edge_sel(cmp_edge),
		.edge_other()
	);

	// timer input edges, shared by counter, capture and gated modes
	tmr_edge u_tin_edge
	(
		.clk(clk),
		.rst(rst),
		.sig(tmr_in),
		.fall_sel(pol),
		.edge_sel(tin_edge),
		.edge_other(tin_other)
	);

	// byte merge used by the count, reload and pwm registers
	function automatic logic [15:0] put_byte(input logic [15:0] cur, input logic hi,
		input logic [7:0] b);
		put_byte = hi ? {b, cur[7:0]} : {cur[15:8], b};
	endfunction

	// address decode used by both the write side and the mapped check
	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
		is_addr = (a == ofs);
	endfunction

	// control fields
	assign en = ctrl_q[CTRL_EN_BIT];
	assign pol = ctrl_q[CTRL_POL_BIT];
	assign out_en_bit = ctrl_q[CTRL_OUTEN_BIT];
	assign pre_sel = ctrl_q[CTRL_PRE_LSB +: 3];
	assign mode = tmr_mode_t'(ctrl_q[CTRL_MODE_LSB +: 3]);
	assign wr_ctrl = bus.wr && is_addr(bus.addr, OFS_CTRL);

	// mapped address check for the error answer
	assign bus.hit = is_addr(bus.addr, OFS_CTRL) || is_addr(bus.addr, OFS_CNT_H)
		|| is_addr(bus.addr, OFS_CNT_L) || is_addr(bus.addr, OFS_RLD_H)
		|| is_addr(bus.addr, OFS_RLD_L) || is_addr(bus.addr, OFS_PWM_H)
		|| is_addr(bus.addr, OFS_PWM_L) || is_addr(bus.addr, OFS_STAT)
		|| is_addr(bus.addr, OFS_MASK) || is_addr(bus.addr, OFS_CAP_H)
		|| is_addr(bus.addr, OFS_CAP_L);

	// prescaler; divides by two to the power of the select field
	always_ff @(posedge clk)
	begin
		if (rst || !en || pre_tick)
			pre_q <= 8'h00;
		else
			pre_q <= pre_q + 8'h01;
	end

	assign pre_tick = (pre_q == ((8'h01 << pre_sel) - 8'h01));

	// gate level active high for polarity 0, active low for polarity 1
	assign gate_active = (tmr_in != pol);

	// what advances the count in each mode
	always_comb
	begin
		count_step = 1'b0;
		unique case (mode)
			MODE_CMPCNT: count_step = cmp_edge;
			MODE_COUNTER: count_step = tin_edge;
			MODE_GATED: count_step = pre_tick && gate_active;
			MODE_ONESHOT, MODE_CONT, MODE_PWM, MODE_CAPTURE, MODE_COMPARE:
				count_step = pre_tick;
		endcase
		count_step = count_step && en;
	end

	// reload when the count has reached the reload value
	assign at_reload = (cnt_q == rld_q);
	assign reload_ev = count_step && at_reload;
	assign match_ev = en && (mode == MODE_PWM) && count_step && (cnt_q == pwm_q);
	assign capture_ev = en && (mode == MODE_CAPTURE) && tin_edge;
	assign gate_ev = en && (mode == MODE_GATED) && tin_other;

	// count: software write wins so a start value lands even mid-count
	always_ff @(posedge clk)
	begin
		if (rst)
			cnt_q <= CNT_RESET;
		else if (bus.wr && is_addr(bus.addr, OFS_CNT_H))
			cnt_q <= put_byte(cnt_q, 1'b1, bus.wdata[7:0]);
		else if (bus.wr && is_addr(bus.addr, OFS_CNT_L))
			cnt_q <= put_byte(cnt_q, 1'b0, bus.wdata[7:0]);
		else if (reload_ev && mode != MODE_COMPARE)
			cnt_q <= RELOAD_START;
		else if (count_step)
			cnt_q <= cnt_q + 16'h0001;
	end

	// reload and pwm compare values
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rld_q <= RLD_RESET;
			pwm_q <= PWM_RESET;
		end
		else if (bus.wr)
		begin
			if (is_addr(bus.addr, OFS_RLD_H))
				rld_q <= put_byte(rld_q, 1'b1, bus.wdata[7:0]);
			if (is_addr(bus.addr, OFS_RLD_L))
				rld_q <= put_byte(rld_q, 1'b0, bus.wdata[7:0]);
			if (is_addr(bus.addr, OFS_PWM_H))
				pwm_q <= put_byte(pwm_q, 1'b1, bus.wdata[7:0]);
			if (is_addr(bus.addr, OFS_PWM_L))
				pwm_q <= put_byte(pwm_q, 1'b0, bus.wdata[7:0]);
		end
	end

	// captured count, read back through its own byte pair
	always_ff @(posedge clk)
	begin
		if (rst)
			cap_q <= CNT_RESET;
		else if (capture_ev)
			cap_q <= cnt_q;
	end

	// control; one-shot drops its own enable at reload
	always_ff @(posedge clk)
	begin
		if (rst)
			ctrl_q <= CTRL_RESET;
		else if (wr_ctrl)
			ctrl_q <= bus.wdata[CTRL_W-1:0];
		else if (reload_ev && mode == MODE_ONESHOT)
			ctrl_q[CTRL_EN_BIT] <= 1'b0;
	end

	// timer output level per mode; disabled level is the polarity bit
	always_ff @(posedge clk)
	begin
		if (rst)
			out_q <= 1'b0;
		else if (!en)
			out_q <= pol;
		else if (mode == MODE_PWM)
		begin
			if (reload_ev)
				out_q <= pol;
			else if (match_ev)
				out_q <= ~pol;
		end
		else if (reload_ev && mode != MODE_CAPTURE && mode != MODE_GATED)
			out_q <= ~out_q;
	end

	// pin drive level follows the internal level one cycle later, not gated by the enable
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tmr_out <= 1'b0;
			out_en_q <= 1'b0;
		end
		else
		begin
			tmr_out <= out_q;
			out_en_q <= out_en_bit;
		end
	end

	assign tmr_out_en = out_en_q;

	// sticky events; a set in the clearing cycle survives
	always_comb
	begin
		stat_set = '0;
		stat_set[ST_RELOAD] = reload_ev;
		stat_set[ST_CAPTURE] = capture_ev;
		stat_set[ST_GATE] = gate_ev;
		stat_set[ST_MATCH] = match_ev;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			stat_q <= '0;
		else if (bus.wr && is_addr(bus.addr, OFS_STAT))
			stat_q <= (stat_q & ~bus.wdata[ST_W-1:0]) | stat_set;
		else
			stat_q <= stat_q | stat_set;
	end

	// mask register, 1 lets a status bit reach the interrupt
	always_ff @(posedge clk)
	begin
		if (rst)
			mask_q <= '0;
		else if (bus.wr && is_addr(bus.addr, OFS_MASK))
			mask_q <= bus.wdata[ST_W-1:0];
	end

	// interrupt lags status by one cycle so it comes from a flop
	always_ff @(posedge clk)
	begin
		if (rst)
			irq_q <= 1'b0;
		else
			irq_q <= |(stat_q & mask_q);
	end

	assign irq = irq_q;

	// read mux; narrow registers sit in the low bits, the rest reads zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (bus.addr)
			OFS_CTRL: rd_mux[CTRL_W-1:0] = ctrl_q;
			OFS_CNT_H: rd_mux[7:0] = cnt_q[15:8];
			OFS_CNT_L: rd_mux[7:0] = cnt_q[7:0];
			OFS_RLD_H: rd_mux[7:0] = rld_q[15:8];
			OFS_RLD_L: rd_mux[7:0] = rld_q[7:0];
			OFS_PWM_H: rd_mux[7:0] = pwm_q[15:8];
			OFS_PWM_L: rd_mux[7:0] = pwm_q[7:0];
			OFS_STAT: rd_mux[ST_W-1:0] = stat_q;
			OFS_MASK: rd_mux[ST_W-1:0] = mask_q;
			OFS_CAP_H: rd_mux[7:0] = cap_q[15:8];
			OFS_CAP_L: rd_mux[7:0] = cap_q[7:0];
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data flop; count bytes are not latched, so read high then low quickly
	always_ff @(posedge clk)
	begin
		if (rst)
			prdata_q <= 32'h0000_0000;
		else if (psel && !pwrite)
			prdata_q <= rd_mux;
	end

	assign prdata = prdata_q;
endmodule
`default_nettype wire

// ==== hw/tmr_pkg.sv ====
// package: register map, field layout, reset values and modes of the timer
`default_nettype none
package tmr_pkg;
	// byte addresses of the word registers on the apb
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CNT_H = 8'h04;
	localparam logic [7:0] OFS_CNT_L = 8'h08;
	localparam logic [7:0] OFS_RLD_H = 8'h0C;
	localparam logic [7:0] OFS_RLD_L = 8'h10;
	localparam logic [7:0] OFS_PWM_H = 8'h14;
	localparam logic [7:0] OFS_PWM_L = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1C;
	localparam logic [7:0] OFS_MASK = 8'h20;
	localparam logic [7:0] OFS_CAP_H = 8'h24;
	localparam logic [7:0] OFS_CAP_L = 8'h28;
	// control register fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_POL_BIT = 4;
	localparam int CTRL_OUTEN_BIT = 5;
	localparam int CTRL_PRE_LSB = 6;
	localparam int CTRL_W = 9;
	// status and mask bits
	localparam int ST_RELOAD = 0;
	localparam int ST_CAPTURE = 1;
	localparam int ST_GATE = 2;
	localparam int ST_MATCH = 3;
	localparam int ST_W = 4;
	// reset values and the count loaded at reload
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] RLD_RESET = 16'hFFFF;
	localparam logic [15:0] PWM_RESET = 16'h0000;
	localparam logic [15:0] RELOAD_START = 16'h0001;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
	typedef enum logic [2:0]
	{
		MODE_ONESHOT = 3'b000,
		MODE_CONT = 3'b001,
		MODE_COUNTER = 3'b010,
		MODE_PWM = 3'b011,
		MODE_CAPTURE = 3'b100,
		MODE_COMPARE = 3'b101,
		MODE_GATED = 3'b110,
		MODE_CMPCNT = 3'b111
	} tmr_mode_t;
endpackage
`default_nettype wire

// ==== hw/tmr_reg_if.sv ====
// interface: register access strobes between the apb slave and the timer core
`default_nettype none
interface tmr_reg_if;
	logic wr; // one-cycle write strobe
	logic [7:0] addr; // byte address of the access
	logic [31:0] wdata; // write data
	logic hit; // address is mapped
	modport slave (output wr, output addr, output wdata, input hit);
	modport regs (input wr, input addr, input wdata, output hit);
endinterface
`default_nettype wire

// ==== hw/tmr_edge.sv ====
// module: edge detector with polarity select for a synchronous input
`default_nettype none
module tmr_edge
	import tmr_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic sig, // sampled input
	input wire logic fall_sel, // 1 selects the falling edge
	output logic edge_sel, // selected edge, one-cycle pulse
	output logic edge_other // opposite edge, one-cycle pulse
);
	logic prev_q;
	logic rise;
	logic fall;

	// previous level; input is already synchronous, so one stage suffices
	always_ff @(posedge clk)
	begin
		if (rst)
			prev_q <= 1'b0;
		else
			prev_q <= sig;
	end

	assign rise = sig & ~prev_q;
	assign fall = ~sig & prev_q;
	assign edge_sel = fall_sel ? fall : rise;
	assign edge_other = fall_sel ? rise : fall;
endmodule
`default_nettype wire

// ==== hw/tmr_apb.sv ====
// module: apb slave front end with one wait state
`default_nettype none
module tmr_apb
	import tmr_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic pready, // apb ready, from a register
	output logic pslverr, // apb error on unmapped address
	tmr_reg_if.slave bus // strobes toward the register file
);
	logic pready_q;
	logic pslverr_q;

	// one wait state gives the read mux a full cycle to settle into its flop
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else if (psel && penable && !pready_q)
		begin
			pready_q <= 1'b1;
			pslverr_q <= ~bus.hit;
		end
		else
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	assign bus.wr = psel & penable & pwrite & pready_q;
	assign bus.addr = paddr;
	assign bus.wdata = pwdata;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule
`default_nettype wire

// ==== tb/tmr_sva.sv ====
// checker: apb timing and output levels of the timer top
`default_nettype none
module tmr_sva
	import tmr_pkg::*;
#(
	parameter int CNT_W = 16 // counter width
)
(
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // direction
	input wire logic [7:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic cmp_out, // comparator
	input wire logic tmr_in, // input pin
	input wire logic tmr_out, // output level
	input wire logic tmr_out_en, // output flag
	input wire logic irq // interrupt
);
	// a control write lands at the edge where pready is seen high
	logic wr_ctrl;
	logic acc;
	assign acc = psel && penable && pready;
	assign wr_ctrl = acc && pwrite && (paddr == OFS_CTRL);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_one_wait; psel && !penable |=> !pready ##1 pready; endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait state wrong");
	property p_rdy_pulse; pready |=> !pready; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
	property p_rdy_acc; pready || pslverr |-> psel && penable && pready; endproperty
	a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
	property p_unmap; acc && (paddr > OFS_CAP_L) |-> pslverr && (pwrite || prdata == 32'h0); endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access");
	property p_outen; wr_ctrl |-> ##3 tmr_out_en == $past(pwdata[5], 3); endproperty
	a_outen: assert property (p_outen) else $error("output flag");
	property p_dis; wr_ctrl && !pwdata[0] && pwdata[3:1] inside {3'b000, 3'b001, 3'b101}
		|-> ##4 tmr_out == $past(pwdata[4], 4); endproperty
	a_dis: assert property (p_dis) else $error("idle level");
	property p_pwm; wr_ctrl && pwdata[3:0] == 4'h6 |-> ##4 tmr_out == $past(pwdata[4], 4); endproperty
	a_pwm: assert property (p_pwm) else $error("pwm idle level");
	property p_cmp; wr_ctrl && pwdata[3:0] == 4'hE |-> ##4 tmr_out == $past(pwdata[4], 4); endproperty
	a_cmp: assert property (p_cmp) else $error("comparator idle level");
endmodule
`default_nettype wire

// ==== tb/tmr_pins.sv ====
// model: comparator output and timer input pin drivers
`default_nettype none
module tmr_pins
(
	input wire logic clk, // clock
	output logic cmp_out, // comparator level
	output logic tmr_in // input pin level
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cmp_out = 1'b0;
		tmr_in = 1'b0;
	end
	// levels held two clocks: the counter also sees levels held only one clock
	task automatic cmp_rises(input int n);
		repeat (2 * n)
		begin
			cmp_out <= ~cmp_out;
			repeat (2) @(posedge clk);
		end
	endtask
	task automatic set_in(input logic v);
		tmr_in <= v;
		repeat (3) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// testbench: register access and pin stimulus for the timer
`default_nettype none
module tb
	import tmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, cmp_out, tmr_in, tmr_out;
	logic tmr_out_en, irq, pe;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int bad_count, check_count;
	tmr_mode_t md[5] = '{MODE_ONESHOT, MODE_CONT, MODE_PWM, MODE_COMPARE, MODE_CMPCNT};
	tmr_top tmr_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmp_out(cmp_out), .tmr_in(tmr_in), .tmr_out(tmr_out),
		.tmr_out_en(tmr_out_en), .irq(irq));
	tmr_pins tmr_pins_inst (.clk(clk), .cmp_out(cmp_out), .tmr_in(tmr_in));
	// clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask
	// one apb transfer; pready and read data are taken at the rising edge that ends it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			bad_count++;
			summarize();
		end
		q = prdata;
		pe = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("register", e, q & m);
	endtask
	task automatic pins(input logic eo, input logic ei);
		repeat (2) @(negedge clk);
		chk("tmr_out", {31'h0, eo}, {31'h0, tmr_out});
		chk("irq", {31'h0, ei}, {31'h0, irq});
		@(posedge clk);
	endtask
	// main sequence
	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		bad_count = 0;
		check_count = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(OFS_CTRL, 32'h1FF, 32'h0);
		rdc(OFS_RLD_H, 32'hFF, 32'hFF);
		rdc(OFS_RLD_L, 32'hFF, 32'hFF);
		rdc(8'h30, 32'hFFFFFFFF, 32'h0);
		chk("slverr", 32'h1, {31'h0, pe});
		pins(1'b0, 1'b0);
		// idle level follows polarity in one-shot, continuous, pwm, compare and comparator counting modes
		for (int p = 0; p < 2; p++)
			foreach (md[i])
			begin
				wr(OFS_CTRL, {27'h0, p[0], md[i], 1'b0});
				pins(p[0], 1'b0);
			end
		// comparator counting with the slowest prescale selected
		wr(OFS_CTRL, 32'h1CE);
		wr(OFS_CNT_H, 32'h0);
		wr(OFS_CNT_L, 32'h5);
		wr(OFS_RLD_H, 32'h0);
		wr(OFS_RLD_L, 32'h7);
		wr(OFS_MASK, 32'h1);
		wr(OFS_CTRL, 32'h1EF);
		tmr_pins_inst.cmp_rises(2);
		rdc(OFS_CNT_L, 32'hFF, 32'h7);
		rdc(OFS_CNT_H, 32'hFF, 32'h0);
		tmr_pins_inst.cmp_rises(1);
		rdc(OFS_CNT_L, 32'hFF, 32'h1);
		rdc(OFS_STAT, 32'hF, 32'h1);
		pins(1'b1, 1'b1);
		wr(OFS_MASK, 32'h0);
		pins(1'b1, 1'b0);
		wr(OFS_STAT, 32'h1);
		rdc(OFS_STAT, 32'hF, 32'h0);
		wr(OFS_MASK, 32'h1);
		tmr_pins_inst.cmp_rises(6);
		rdc(OFS_CNT_L, 32'hFF, 32'h7);
		tmr_pins_inst.cmp_rises(1);
		rdc(OFS_CNT_L, 32'hFF, 32'h1);
		pins(1'b0, 1'b1);
		// counter mode counts falling input edges
		wr(OFS_CTRL, 32'h14);
		wr(OFS_CNT_L, 32'h0);
		wr(OFS_CTRL, 32'h15);
		tmr_pins_inst.set_in(1'b1);
		tmr_pins_inst.set_in(1'b0);
		rdc(OFS_CNT_L, 32'hFF, 32'h1);
		// capture on the rising input edge only
		wr(OFS_CTRL, 32'h09);
		wr(OFS_STAT, 32'hF);
		tmr_pins_inst.set_in(1'b1);
		rdc(OFS_STAT, 32'h2, 32'h2);
		wr(OFS_STAT, 32'hF);
		tmr_pins_inst.set_in(1'b0);
		rdc(OFS_STAT, 32'h2, 32'h0);
		// gated mode holds while the input is low and flags its falling edge
		wr(OFS_CTRL, 32'h0C);
		wr(OFS_CNT_L, 32'h3);
		wr(OFS_CTRL, 32'h0D);
		rdc(OFS_CNT_L, 32'hFF, 32'h3);
		wr(OFS_STAT, 32'hF);
		tmr_pins_inst.set_in(1'b1);
		rdc(OFS_STAT, 32'h4, 32'h0);
		tmr_pins_inst.set_in(1'b0);
		rdc(OFS_STAT, 32'h4, 32'h4);
		// pwm at the slowest prescale: match at two sets the output, reload at seven clears it
		wr(OFS_CTRL, 32'h1C6);
		wr(OFS_CNT_H, 32'h0);
		wr(OFS_CNT_L, 32'h0);
		wr(OFS_PWM_L, 32'h2);
		wr(OFS_STAT, 32'hF);
		wr(OFS_CTRL, 32'h1C7);
		repeat (440) @(posedge clk);
		pins(1'b1, 1'b0);
		repeat (640) @(posedge clk);
		pins(1'b0, 1'b1);
		rdc(OFS_STAT, 32'h8, 32'h8);
		// reset in mid-run returns registers and pins to their idle state
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(OFS_STAT, 32'hF, 32'h0);
		rdc(OFS_CNT_L, 32'hFF, 32'h0);
		rdc(OFS_CTRL, 32'h1FF, 32'h0);
		pins(1'b0, 1'b0);
		summarize();
	end
endmodule
bind tmr_top tmr_sva #(.CNT_W(CNT_W)) tmr_sva_inst (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .cmp_out(cmp_out), .tmr_in(tmr_in),
	.tmr_out(tmr_out), .tmr_out_en(tmr_out_en), .irq(irq));
`default_nettype wire
